/* File: core/flash_info_pkg.sv */
// constants for the flash controller identity and configuration registers
// assumes a 32-bit classic wishbone slave with byte addresses
package flash_info_pkg;
    localparam int          ADDR_W          = 12;
    // register byte offsets
    localparam logic [11:0] OFF_VECTOR_SEL  = 12'h100;
    localparam logic [11:0] OFF_MAKER_PART  = 12'h180;
    localparam logic [11:0] OFF_PAGE_COUNT  = 12'h184;
    localparam logic [11:0] OFF_PAGE_SIZE   = 12'h188;
    localparam logic [11:0] OFF_FULL_PART   = 12'h18c;
    localparam logic [11:0] OFF_PF_WAIT     = 12'h200;
    localparam logic [11:0] OFF_CUSTOM_0    = 12'h310;
    localparam logic [11:0] OFF_CUSTOM_3    = 12'h31c;
    // field positions
    localparam int          VMS_BIT         = 1;
    localparam int          PFE_BIT         = 4;
    localparam int          WAIT_LSB        = 0;
    localparam int          WAIT_W          = 3;
    localparam int          PART_FULL_W     = 20;
    // reset values
    localparam logic [31:0] PF_WAIT_RESET   = 32'h0000_0011;
    localparam logic [31:0] PAGE_SIZE_RESET = 32'h0000_0400;
    // vector area: byte addresses 0x0 to 0xc
    localparam logic [31:0] VEC_LAST_ADDR   = 32'h0000_000c;
endpackage

/* File: core/fetch_wait_gen.sv */
// non-sequential access wait generator for the flash fetch path
// assumes a request strobe from the fetch port on the same clock
module fetch_wait_gen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic [2:0] waitCode,
    input  wire logic       req,
    input  wire logic       seqAccess,
    // status
    output logic            ready
);
    logic [2:0] cnt_q;
    logic       busy_q;

    // non-sequential takes waitCode-1 stall cycles for codes 2 to 7 and none for codes 0 and 1, sequential none
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q  <= 3'h0;
            busy_q <= 1'b0;
        end else if (!busy_q && req && !seqAccess && waitCode > 3'h1) begin
            cnt_q  <= waitCode - 3'h2;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == 3'h0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    // request cycle is the first stall; busy covers the rest, and the
    // last busy cycle (count zero) already answers
    assign ready = busy_q ? (cnt_q == 3'h0)
        : !(req && !seqAccess && waitCode > 3'h1);
endmodule

/* File: core/flash_info_regs.sv */
// identity, geometry, vector map and prefetch/wait registers
// assumes classic wishbone master, bootSelect from a pin, custom
// words loaded from the flash privilege block by the controller

module flash_info_regs
    import flash_info_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h0a5a, // arbitrary value
    parameter logic [15:0] PART_CODE4 = 16'h1234, // arbitrary value
    parameter logic [19:0] PART_CODE5 = 20'h0_1234, // arbitrary value
    parameter logic [31:0] PAGE_COUNT = 32'h0000_0020,
    parameter logic [31:0] PAGE_SIZE  = flash_info_pkg::PAGE_SIZE_RESET
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // boot strap pin
    input  wire logic        bootSelect,
    // custom identity words from flash
    input  wire logic [31:0] customWord [4],
    // processor fetch port
    input  wire logic        fetchReq,
    input  wire logic        fetchSeq,
    input  wire logic [31:0] fetchAddr,
    // fetch steering outputs
    output logic             vectorFromMain,
    output logic             prefetchOn,
    output logic             fetchReady,
    output logic             useBootArea
);
    import flash_info_pkg::*;

    logic        boot1_q;
    logic        boot2_q;
    logic        strapPend_q;
    logic        vecSel_q;
    logic        pfEn_q;
    logic [2:0]  waitCode_q;
    logic [31:0] rdata_d;
    logic        access;
    logic        wrStrobe;
    logic        fetchReadyW;
    logic        inVector;

    assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrStrobe = access && wb_we_i;

    // boot pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        boot1_q <= bootSelect;
        boot2_q <= boot1_q;
    end

    // strap is caught after reset release through the synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            strapPend_q <= 1'b1;
        end else begin
            strapPend_q <= 1'b0;
        end
    end

    // vector map select: strap after reset, software may override
    always_ff @(posedge clk) begin
        if (rst) begin
            vecSel_q <= 1'b0;
        end else if (strapPend_q) begin
            vecSel_q <= boot2_q;
        end else if (wrStrobe && wb_adr_i == OFF_VECTOR_SEL
                     && wb_sel_i[0]) begin
            vecSel_q <= wb_dat_i[VMS_BIT];
        end
    end

    // prefetch enable and wait code; lane 0 holds both fields
    always_ff @(posedge clk) begin
        if (rst) begin
            pfEn_q     <= PF_WAIT_RESET[PFE_BIT];
            waitCode_q <= PF_WAIT_RESET[WAIT_W-1:0];
        end else if (wrStrobe && wb_adr_i == OFF_PF_WAIT
                     && wb_sel_i[0]) begin
            pfEn_q     <= wb_dat_i[PFE_BIT];
            waitCode_q <= wb_dat_i[WAIT_W-1:0]; // reserved codes kept
        end
    end

    // read mux; writes to read-only words simply fall away
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_VECTOR_SEL: rdata_d[VMS_BIT] = vecSel_q;
            OFF_MAKER_PART: rdata_d = {MAKER_CODE, PART_CODE4};
            OFF_PAGE_COUNT: rdata_d = PAGE_COUNT;
            OFF_PAGE_SIZE:  rdata_d = PAGE_SIZE;
            OFF_FULL_PART:  rdata_d = {12'h000, PART_CODE5};
            OFF_PF_WAIT: begin
                rdata_d[PFE_BIT]     = pfEn_q;
                rdata_d[WAIT_W-1:0]  = waitCode_q;
            end
            OFF_CUSTOM_0:   rdata_d = customWord[0];
            12'h314:        rdata_d = customWord[1];
            12'h318:        rdata_d = customWord[2];
            OFF_CUSTOM_3:   rdata_d = customWord[3];
            default:        rdata_d = 32'h0000_0000;
        endcase
    end

    // one wait state answer; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= access ? rdata_d : 32'h0000_0000;
        end
    end

    fetch_wait_gen u_wait (
        .clk       (clk),
        .rst       (rst),
        .waitCode  (waitCode_q),
        .req       (fetchReq),
        .seqAccess (fetchSeq),
        .ready     (fetchReadyW)
    );

    assign inVector = fetchAddr <= VEC_LAST_ADDR;

    // fetch steering outputs, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            vectorFromMain <= 1'b0;
            prefetchOn     <= 1'b1;
            fetchReady     <= 1'b0;
            useBootArea    <= 1'b0;
        end else begin
            vectorFromMain <= vecSel_q;
            prefetchOn     <= pfEn_q; // off: reads go straight to array
            fetchReady     <= fetchReadyW;
            useBootArea    <= fetchReq && inVector && !vecSel_q;
        end
    end

    // assertions
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_strap_loaded: assert property (@(posedge clk)
        $fell(strapPend_q) |-> vecSel_q == $past(boot2_q))
        else $error("strap not loaded");
    a_pfe_reset: assert property (@(posedge clk)
        $past(rst) |-> pfEn_q && waitCode_q == 3'h1)
        else $error("prefetch reset wrong");
    a_vec_route: assert property (@(posedge clk) disable iff (rst)
        fetchReq && fetchAddr == 32'h0 && !vecSel_q |=> useBootArea)
        else $error("vector not routed to boot area");
    a_main_route: assert property (@(posedge clk) disable iff (rst)
        vecSel_q |=> !useBootArea) else $error("main flash ignored");
    a_maker_read: assert property (@(posedge clk) disable iff (rst)
        access && !wb_we_i && wb_adr_i == OFF_MAKER_PART
        |=> wb_dat_o[31:16] == MAKER_CODE) else $error("maker code wrong");
    a_part_read: assert property (@(posedge clk) disable iff (rst)
        access && wb_adr_i == OFF_FULL_PART
        |=> wb_dat_o[31:20] == 12'h000) else $error("reserved not zero");
    a_size_read: assert property (@(posedge clk) disable iff (rst)
        access && wb_adr_i == OFF_PAGE_SIZE |=> wb_dat_o == PAGE_SIZE)
        else $error("page size wrong");
    a_sw_write: assert property (@(posedge clk) disable iff (rst)
        !strapPend_q && wrStrobe && wb_adr_i == OFF_VECTOR_SEL
        && wb_sel_i[0] |=> vecSel_q == $past(wb_dat_i[VMS_BIT]))
        else $error("vector select write lost");
    a_wait_stall: assert property (@(posedge clk) disable iff (rst)
        fetchReq && !fetchSeq && waitCode_q == 3'h2 && fetchReadyW
        |=> !fetchReadyW) else $error("wait cycle missing");
    a_seq_nowait: assert property (@(posedge clk) disable iff (rst)
        fetchSeq && fetchReadyW |=> fetchReady) else $error("seq stalled");
    a_custom_read: assert property (@(posedge clk) disable iff (rst)
        access && wb_adr_i == OFF_CUSTOM_0 |=> wb_dat_o == $past(customWord[0]))
        else $error("custom word wrong");
    a_count_read: assert property (@(posedge clk) disable iff (rst)
        access && wb_adr_i == OFF_PAGE_COUNT |=> wb_dat_o == PAGE_COUNT)
        else $error("page count wrong");
    a_id_low: assert property (@(posedge clk) disable iff (rst)
        access && wb_adr_i == OFF_MAKER_PART |=> wb_dat_o[15:0] == PART_CODE4)
        else $error("part code wrong");
endmodule

/* File: verif/flash_info_regs_tb.sv */
// self-checking bench for the flash identity and configuration registers
// assumes the register block answers every wishbone access one cycle late
module flash_info_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_info_pkg::*;
    localparam logic [15:0] MK = 16'h5a3c; // arbitrary value
    localparam logic [15:0] P4 = 16'h4321; // arbitrary value
    localparam logic [19:0] P5 = 20'h5_4321; // arbitrary value
    localparam logic [31:0] PC = 32'h0000_0080;
    logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, bootSelect;
    logic [11:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW, wbDatR, fetchAddr, seed;
    logic [31:0] customWord [4];
    logic        fetchReq, fetchSeq, vectorFromMain, prefetchOn;
    logic        fetchReady, useBootArea;
    logic [31:0] expQ [$];
    logic [11:0] roAdr [8];
    logic [31:0] roExp [8];
    int          num_errors, samples_checked;

    flash_info_regs #(.MAKER_CODE(MK), .PART_CODE4(P4), .PART_CODE5(P5),
        .PAGE_COUNT(PC)) DUT (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .bootSelect(bootSelect), .customWord(customWord),
        .fetchReq(fetchReq), .fetchSeq(fetchSeq), .fetchAddr(fetchAddr),
        .vectorFromMain(vectorFromMain), .prefetchOn(prefetchOn),
        .fetchReady(fetchReady), .useBootArea(useBootArea));

    // free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // read data is taken at the ack edge, so the watcher pairs it with notes
    always @(posedge clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (expQ.size() == 0) check(wbDatR, 32'hxxxx_xxxx);
            else check(wbDatR, expQ.pop_front());
        end
    end

    // one classic cycle; held until ack, then one idle cycle
    task bus(input logic we, input logic [11:0] adr, input logic [31:0] d);
        int n;
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr;
        wbDatW <= d; wbSel <= 4'hf; n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1) begin
            num_errors++;
            test_done();
        end
        wbCyc <= 1'b0; wbStb <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [11:0] adr, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b0, adr, 32'h0000_0000);
    endtask

    task doReset;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // strap lands one edge after release, its output copy one later
        repeat (3) @(posedge clk);
    endtask

    // a sequential fetch shows whether the boot area served it
    task vecProbe(input logic [31:0] a, input logic exp);
        fetchReq <= 1'b1; fetchSeq <= 1'b1; fetchAddr <= a;
        repeat (2) @(posedge clk);
        check({31'h0, useBootArea}, {31'h0, exp});
        fetchReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // counts stall cycles; the first edge still shows the idle value
    task fetchWait(input logic seq, input int expLow);
        int low, n;
        fetchReq <= 1'b1; fetchSeq <= seq; fetchAddr <= 32'h0000_0100;
        low = 0; n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 1 && fetchReady !== 1'b1) low++;
        end while (!(n > 1 && fetchReady === 1'b1) && n < 16);
        check(low, expLow);
        if (fetchReady !== 1'b1) test_done();
        fetchReq <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        seed = 32'hfd4b_142e; rst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0;
        wbWe = 1'b0; wbAdr = 12'h000; wbSel = 4'h0; wbDatW = 32'h0;
        bootSelect = 1'b1; fetchReq = 1'b0; fetchSeq = 1'b0; fetchAddr = 32'h0;
        num_errors = 0; samples_checked = 0;
        for (int i = 0; i < 4; i++) customWord[i] = rnd();
        roAdr = '{OFF_MAKER_PART, OFF_PAGE_COUNT, OFF_PAGE_SIZE, OFF_FULL_PART,
            OFF_CUSTOM_0, 12'h314, 12'h318, OFF_CUSTOM_3};
        roExp = '{{MK, P4}, PC, PAGE_SIZE_RESET, {12'h000, P5}, customWord[0],
            customWord[1], customWord[2], customWord[3]};
        doReset();
        check({31'h0, vectorFromMain}, 32'h1);
        rd(OFF_VECTOR_SEL, 32'h0000_0002);
        check({31'h0, prefetchOn}, 32'h1);
        rd(OFF_PF_WAIT, PF_WAIT_RESET);
        vecProbe(32'h0000_0008, 1'b0);
        bus(1'b1, OFF_VECTOR_SEL, 32'h0000_0000);
        rd(OFF_VECTOR_SEL, 32'h0000_0000);
        check({31'h0, vectorFromMain}, 32'h0);
        vecProbe(32'h0000_000c, 1'b1);
        vecProbe(32'h0000_0010, 1'b0);
        // read-only places keep their value after a random write
        for (int i = 0; i < 8; i++) begin
            rd(roAdr[i], roExp[i]);
            bus(1'b1, roAdr[i], rnd());
            rd(roAdr[i], roExp[i]);
        end
        bus(1'b1, 12'h3f0, rnd());
        rd(12'h3f0, 32'h0000_0000);
        bus(1'b1, OFF_PF_WAIT, 32'hffff_ffe1);
        rd(OFF_PF_WAIT, 32'h0000_0001);
        check({31'h0, prefetchOn}, 32'h0);
        fetchWait(1'b0, 0);
        bus(1'b1, OFF_PF_WAIT, 32'h0000_0012);
        rd(OFF_PF_WAIT, 32'h0000_0012);
        fetchWait(1'b0, 1);
        fetchWait(1'b1, 0);
        bootSelect <= 1'b0;
        doReset();
        rd(OFF_VECTOR_SEL, 32'h0000_0000);
        check({31'h0, vectorFromMain}, 32'h0);
        test_done();
    end
endmodule
